// File: drive_ramp_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB word registers, 100 MHz pclk
// Notes: Frequencies in 0.01 Hz, percentages in 0.1 %, delays in 0.01 s
`ifndef DRIVE_RAMP_DEFINES_SVH
`define DRIVE_RAMP_DEFINES_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define DELAY_TICK_NS 10000000
`define DELAY_TICK_CYCLES (`DELAY_TICK_NS / `CLK_PERIOD_NS)
`define PCT_FULL_SCALE 32'd1000

// ==========================================================
// Register indices, byte address is index times four
`define IDX_CTRL 5'd0
`define IDX_HOP1 5'd1
`define IDX_HOP2 5'd2
`define IDX_HOP_AMP 5'd3
`define IDX_ACCEL_POINT 5'd4
`define IDX_DECEL_POINT 5'd5
`define IDX_FIRST_LEVEL 5'd6
`define IDX_FIRST_HYST 5'd7
`define IDX_SECOND_LEVEL 5'd8
`define IDX_SECOND_HYST 5'd9
`define IDX_ARRIVE_A 5'd10
`define IDX_BAND_A 5'd11
`define IDX_ARRIVE_B 5'd12
`define IDX_BAND_B 5'd13
`define IDX_ZERO_LEVEL 5'd14
`define IDX_ZERO_DELAY 5'd15
`define IDX_OC_LIMIT 5'd16
`define IDX_OC_DELAY 5'd17
`define IDX_MAX_FREQ 5'd18
`define CFG_COUNT 5'd19
`define IDX_STATUS 5'd19
`define IDX_ACTUAL 5'd20

// ==========================================================
// Control fields
`define CTRL_SKIP_BIT 0
`define CTRL_JOG_BIT 1

// ==========================================================
// Reset values
`define RST_ZERO 16'h0000
`define RST_FREQ_LEVEL 16'h1388
`define RST_HYST 16'h0032
`define RST_ZERO_LEVEL 16'h0032
`define RST_ZERO_DELAY 16'h000a
`define RST_OC_LIMIT 16'h07d0
`define RST_MAX_FREQ 16'h1388

`endif

// File: drive_ramp_pkg.sv
// Purpose: Types shared by the ramp and level detect logic
// Assumes: 16-bit fixed point quantities
// Notes: Constants live in the defines header
package drive_ramp_pkg;

	typedef logic [15:0] value_t;

	typedef struct packed {
		value_t ramp_freq;
		value_t run_freq;
		value_t out_freq;
		value_t out_current;
	} feedback_t;

	typedef struct packed {
		logic run_cmd;
		logic jog_cmd;
		logic accelerating;
		logic decelerating;
		logic motor1_selected;
		logic terminal_ramp_select;
	} drive_cmd_t;

	typedef struct packed {
		logic over_current;
		logic zero_current;
		logic arrive_b;
		logic arrive_a;
		logic second_freq;
		logic first_freq;
	} level_flags_t;

	typedef struct packed {
		logic decel_use_set2;
		logic accel_use_set2;
		logic freq_switch_active;
	} ramp_sel_t;

	typedef enum logic [2:0] {
		st_stopped = 3'b001,
		st_normal = 3'b010,
		st_jog = 3'b100
	} run_state_t;

	typedef enum logic [1:0] {
		skip_up = 2'b01,
		skip_down = 2'b10,
		skip_nearest = 2'b11
	} skip_mode_t;

endpackage

// File: persist_timer.sv
// Purpose: Delay qualification of a current comparison
// Assumes: Delay counted in ticks of tick_cycles clocks
// Notes: Flag follows the condition down on the next edge
`timescale 1ns/100ps
`include "drive_ramp_defines.svh"

module persist_timer #(
	parameter int unsigned tick_cycles = `DELAY_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cond,
	input wire drive_ramp_pkg::value_t delay,
	output logic flag
);
	localparam int unsigned pre_w = $clog2(tick_cycles + 1);

	generate
		if (tick_cycles < 1) begin : g_bad
			$error("tick_cycles must be at least one");
		end
	endgenerate

	logic [pre_w-1:0] pre;
	logic [16:0] ticks;
	logic tick_now;

	assign tick_now = (pre == pre_w'(tick_cycles - 1));

	// ==========================================================
	// Prescaler and tick count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre <= '0;
		end else if (!cond || tick_now) begin
			pre <= '0;
		end else begin
			pre <= pre + 1'b1;
		end
	end

	// Saturates one tick past the delay so a long hold cannot wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ticks <= '0;
		end else if (!cond) begin
			ticks <= '0;
		end else if (tick_now && ticks <= {1'b0, delay}) begin
			ticks <= ticks + 17'h00001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else begin
			flag <= cond && (ticks > {1'b0, delay});
		end
	end

	// ==========================================================
	// Checks
	property p_flag_cause;
		@(posedge pclk) disable iff (!presetn)
		flag |-> $past(cond) && ($past(ticks) > {1'b0, $past(delay)});
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag without expired delay");

	property p_restart;
		@(posedge pclk) disable iff (!presetn)
		!cond |=> ticks == 17'h00000 && pre == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("timer did not restart");

	property p_drop;
		@(posedge pclk) disable iff (!presetn)
		!cond |=> !flag;
	endproperty
	a_drop: assert property (p_drop) else $error("flag held after condition lapsed");

endmodule

// File: drive_ramp_and_level_detect.sv
// Purpose: Skip bands, ramp time switching, jog priority and level flags
// Assumes: APB slave, zero wait states, inputs synchronous to pclk
// Notes: Read data is captured in the setup phase
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "drive_ramp_defines.svh"

module drive_ramp_and_level_detect #(
	parameter int unsigned tick_cycles = `DELAY_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire drive_ramp_pkg::feedback_t feedback,
	input wire drive_ramp_pkg::drive_cmd_t cmd,
	output drive_ramp_pkg::value_t actual_freq,
	output drive_ramp_pkg::ramp_sel_t ramp_sel,
	output drive_ramp_pkg::level_flags_t flags,
	output drive_ramp_pkg::run_state_t run_state
);
	generate
		if (tick_cycles < 1) begin : g_bad
			$error("tick_cycles must be at least one");
		end
	endgenerate

	drive_ramp_pkg::value_t cfg [`CFG_COUNT];
	drive_ramp_pkg::run_state_t next_run_state;
	drive_ramp_pkg::value_t next_actual;
	logic [4:0] idx;
	logic mapped;
	logic ramping;
	logic skip_en;
	logic hops_set;
	logic freq_switch_active;
	logic zero_cond;
	logic oc_cond;
	logic oc_raw;
	logic first_hit, second_hit, arrive_a_hit, arrive_b_hit, zero_hit;

	// ==========================================================
	// Helpers
	function automatic drive_ramp_pkg::value_t pct_of(input drive_ramp_pkg::value_t v,
			input drive_ramp_pkg::value_t p);
		logic [31:0] prod;
		prod = v * p;
		prod = prod / `PCT_FULL_SCALE;
		return prod[15:0];
	endfunction

	function automatic drive_ramp_pkg::value_t abs_diff(input drive_ramp_pkg::value_t a,
			input drive_ramp_pkg::value_t b);
		return (a > b) ? a - b : b - a;
	endfunction

	function automatic drive_ramp_pkg::value_t band_lo(input drive_ramp_pkg::value_t h,
			input drive_ramp_pkg::value_t amp);
		return (h > amp) ? h - amp : 16'h0000;
	endfunction

	function automatic drive_ramp_pkg::value_t band_hi(input drive_ramp_pkg::value_t h,
			input drive_ramp_pkg::value_t amp);
		logic [16:0] sum;
		sum = {1'b0, h} + {1'b0, amp};
		return sum[16] ? 16'hffff : sum[15:0];
	endfunction

	function automatic logic in_band(input drive_ramp_pkg::value_t f,
			input drive_ramp_pkg::value_t h, input drive_ramp_pkg::value_t amp);
		return (h != 16'h0000) && (f > band_lo(h, amp)) && (f < band_hi(h, amp));
	endfunction

	// Moves a frequency inside a band to one of its edges
	function automatic drive_ramp_pkg::value_t skip_band(input drive_ramp_pkg::value_t f,
			input drive_ramp_pkg::value_t h, input drive_ramp_pkg::value_t amp,
			input drive_ramp_pkg::skip_mode_t mode);
		drive_ramp_pkg::value_t lo;
		drive_ramp_pkg::value_t hi;
		lo = band_lo(h, amp);
		hi = band_hi(h, amp);
		if (!in_band(f, h, amp)) begin
			return f;
		end
		case (mode)
			drive_ramp_pkg::skip_up: return hi;
			drive_ramp_pkg::skip_down: return lo;
			default: return ((f - lo) <= (hi - f)) ? lo : hi;
		endcase
	endfunction

	// ==========================================================
	// APB slave
	assign idx = paddr[6:2];
	assign mapped = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'b00) && (idx <= `IDX_ACTUAL);
	assign pready = 1'b1;
	// Status words are read only, so a write to them is refused as well
	assign pslverr = psel && penable && (!mapped || (pwrite && idx >= `CFG_COUNT));

	function automatic drive_ramp_pkg::value_t cfg_reset(input int i);
		case (i)
			`IDX_FIRST_LEVEL, `IDX_SECOND_LEVEL, `IDX_ARRIVE_A, `IDX_ARRIVE_B: return `RST_FREQ_LEVEL;
			`IDX_FIRST_HYST, `IDX_SECOND_HYST: return `RST_HYST;
			`IDX_ZERO_LEVEL: return `RST_ZERO_LEVEL;
			`IDX_ZERO_DELAY: return `RST_ZERO_DELAY;
			`IDX_OC_LIMIT: return `RST_OC_LIMIT;
			`IDX_MAX_FREQ: return `RST_MAX_FREQ;
			default: return `RST_ZERO;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `CFG_COUNT; i++) begin
				cfg[i] <= cfg_reset(i);
			end
		end else if (psel && penable && pwrite && mapped && idx < `CFG_COUNT) begin
			cfg[idx] <= pwdata[15:0];
		end
	end

	// Captured in setup so prdata is a flop and pready can stay high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			if (!mapped) begin
				prdata <= 32'h00000000;
			end else if (idx == `IDX_STATUS) begin
				prdata <= {20'h00000, run_state, ramp_sel, flags};
			end else if (idx == `IDX_ACTUAL) begin
				prdata <= {16'h0000, actual_freq};
			end else begin
				prdata <= {16'h0000, cfg[idx]};
			end
		end
	end

	// ==========================================================
	// Skip bands
	assign ramping = cmd.accelerating || cmd.decelerating;
	assign skip_en = cfg[`IDX_CTRL][`CTRL_SKIP_BIT];
	assign hops_set = (cfg[`IDX_HOP1] != 16'h0000) || (cfg[`IDX_HOP2] != 16'h0000);

	always_comb begin
		drive_ramp_pkg::skip_mode_t mode;
		mode = drive_ramp_pkg::skip_nearest;
		if (cmd.accelerating) begin
			mode = drive_ramp_pkg::skip_up;
		end else if (cmd.decelerating) begin
			mode = drive_ramp_pkg::skip_down;
		end
		next_actual = feedback.ramp_freq;
		if (hops_set && (skip_en || !ramping)) begin
			next_actual = skip_band(next_actual, cfg[`IDX_HOP1], cfg[`IDX_HOP_AMP], mode);
			next_actual = skip_band(next_actual, cfg[`IDX_HOP2], cfg[`IDX_HOP_AMP], mode);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			actual_freq <= 16'h0000;
		end else begin
			actual_freq <= next_actual;
		end
	end

	// ==========================================================
	// Ramp time set selection
	assign freq_switch_active = cmd.motor1_selected && !cmd.terminal_ramp_select;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_sel <= '0;
		end else begin
			ramp_sel.freq_switch_active <= freq_switch_active;
			ramp_sel.accel_use_set2 <= freq_switch_active
				&& (feedback.run_freq < cfg[`IDX_ACCEL_POINT]);
			ramp_sel.decel_use_set2 <= freq_switch_active
				&& (feedback.run_freq < cfg[`IDX_DECEL_POINT]);
		end
	end

	// ==========================================================
	// Run state with jog priority
	always_comb begin
		case (run_state)
			drive_ramp_pkg::st_stopped, drive_ramp_pkg::st_jog: begin
				next_run_state = cmd.jog_cmd ? drive_ramp_pkg::st_jog
					: (cmd.run_cmd ? drive_ramp_pkg::st_normal : drive_ramp_pkg::st_stopped);
			end
			drive_ramp_pkg::st_normal: begin
				if (cmd.jog_cmd && cfg[`IDX_CTRL][`CTRL_JOG_BIT]) begin
					next_run_state = drive_ramp_pkg::st_jog;
				end else if (!cmd.run_cmd) begin
					next_run_state = drive_ramp_pkg::st_stopped;
				end else begin
					next_run_state = drive_ramp_pkg::st_normal;
				end
			end
			default: next_run_state = drive_ramp_pkg::st_stopped;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_state <= drive_ramp_pkg::st_stopped;
		end else begin
			run_state <= next_run_state;
		end
	end

	// ==========================================================
	// Frequency threshold detectors with hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_hit <= 1'b0;
			second_hit <= 1'b0;
		end else begin
			if (feedback.run_freq > cfg[`IDX_FIRST_LEVEL]) begin
				first_hit <= 1'b1;
			end else if (feedback.run_freq < cfg[`IDX_FIRST_LEVEL]
					- pct_of(cfg[`IDX_FIRST_LEVEL], cfg[`IDX_FIRST_HYST])) begin
				first_hit <= 1'b0;
			end
			if (feedback.run_freq > cfg[`IDX_SECOND_LEVEL]) begin
				second_hit <= 1'b1;
			end else if (feedback.run_freq < cfg[`IDX_SECOND_LEVEL]
					- pct_of(cfg[`IDX_SECOND_LEVEL], cfg[`IDX_SECOND_HYST])) begin
				second_hit <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Arrival band detectors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arrive_a_hit <= 1'b0;
			arrive_b_hit <= 1'b0;
		end else begin
			arrive_a_hit <= abs_diff(feedback.out_freq, cfg[`IDX_ARRIVE_A])
				<= pct_of(cfg[`IDX_MAX_FREQ], cfg[`IDX_BAND_A]);
			arrive_b_hit <= abs_diff(feedback.out_freq, cfg[`IDX_ARRIVE_B])
				<= pct_of(cfg[`IDX_MAX_FREQ], cfg[`IDX_BAND_B]);
		end
	end

	// ==========================================================
	// Current detectors
	assign zero_cond = feedback.out_current <= cfg[`IDX_ZERO_LEVEL];
	// A zero limit would otherwise match every current and flag constantly
	assign oc_cond = (cfg[`IDX_OC_LIMIT] != 16'h0000)
		&& (feedback.out_current >= cfg[`IDX_OC_LIMIT]);

	persist_timer #(.tick_cycles(tick_cycles)) zero_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cond(zero_cond),
		.delay(cfg[`IDX_ZERO_DELAY]),
		.flag(zero_hit)
	);

	persist_timer #(.tick_cycles(tick_cycles)) oc_timer (
		.pclk(pclk),
		.presetn(presetn),
		.cond(oc_cond),
		.delay(cfg[`IDX_OC_DELAY]),
		.flag(oc_raw)
	);

	// One driver for the whole flag word, each bit from its own flop
	assign flags = {oc_raw, zero_hit, arrive_b_hit, arrive_a_hit, second_hit, first_hit};

	// ==========================================================
	// Checks
	property p_skip_off;
		@(posedge pclk) disable iff (!presetn)
		ramping && !skip_en |=> actual_freq == $past(feedback.ramp_freq);
	endproperty
	a_skip_off: assert property (p_skip_off) else $error("skip applied while disabled");

	property p_skip_jump;
		@(posedge pclk) disable iff (!presetn)
		ramping && skip_en && hops_set
			|=> !in_band(actual_freq, cfg[`IDX_HOP2], cfg[`IDX_HOP_AMP]);
	endproperty
	a_skip_jump: assert property (p_skip_jump) else $error("frequency dwells in band");

	property p_no_hops;
		@(posedge pclk) disable iff (!presetn)
		!hops_set |=> actual_freq == $past(feedback.ramp_freq);
	endproperty
	a_no_hops: assert property (p_no_hops) else $error("skip active with zero hops");

	property p_switch_off;
		@(posedge pclk) disable iff (!presetn)
		!freq_switch_active |=> !ramp_sel.accel_use_set2 && !ramp_sel.decel_use_set2;
	endproperty
	a_switch_off: assert property (p_switch_off) else $error("set 2 chosen while inactive");

	property p_accel_set;
		@(posedge pclk) disable iff (!presetn)
		freq_switch_active && feedback.run_freq > cfg[`IDX_ACCEL_POINT]
			|=> !ramp_sel.accel_use_set2;
	endproperty
	a_accel_set: assert property (p_accel_set) else $error("wrong acceleration set");

	property p_decel_set;
		@(posedge pclk) disable iff (!presetn)
		freq_switch_active && feedback.run_freq < cfg[`IDX_DECEL_POINT]
			|=> ramp_sel.decel_use_set2 && ramp_sel.freq_switch_active;
	endproperty
	a_decel_set: assert property (p_decel_set) else $error("wrong deceleration set");

	property p_jog;
		@(posedge pclk) disable iff (!presetn)
		run_state == drive_ramp_pkg::st_normal && cmd.jog_cmd && cfg[`IDX_CTRL][`CTRL_JOG_BIT]
			|=> run_state == drive_ramp_pkg::st_jog;
	endproperty
	a_jog: assert property (p_jog) else $error("jog priority not taken");

	property p_fdt_hold;
		@(posedge pclk) disable iff (!presetn)
		flags.second_freq && feedback.run_freq >= cfg[`IDX_SECOND_LEVEL]
			|=> flags.second_freq;
	endproperty
	a_fdt_hold: assert property (p_fdt_hold) else $error("threshold flag dropped early");

	property p_oc_zero;
		@(posedge pclk) disable iff (!presetn)
		cfg[`IDX_OC_LIMIT] == 16'h0000 |=> ##1 !flags.over_current;
	endproperty
	a_oc_zero: assert property (p_oc_zero) else $error("over-current with zero limit");

endmodule

// File: drive_power_model.sv
// Purpose: Power stage stand-in that returns frequency and current feedback
// Assumes: Bench sets the targets, the stage answers one edge later
// Notes: Ideal stage, feedback carries no ripple
`timescale 1ns/100ps

// ==========================================================
// Power stage
module drive_power_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire drive_ramp_pkg::feedback_t target,
	output drive_ramp_pkg::feedback_t feedback
);
	// Registered so the block sees feedback as a real stage would, late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feedback <= '0;
		end else begin
			feedback <= target;
		end
	end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the ramp and level detect block
// Assumes: Short delay ticks, zero wait APB slave
// Notes: Expected flags, except the current flags, come from an integer model kept beside the run
`timescale 1ns/100ps

// ==========================================================
// Bench
module tb_top;
	localparam int unsigned tk = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	drive_ramp_pkg::feedback_t tgt, fb;
	drive_ramp_pkg::drive_cmd_t cmd;
	drive_ramp_pkg::value_t actual_freq;
	drive_ramp_pkg::ramp_sel_t ramp_sel;
	drive_ramp_pkg::level_flags_t flags;
	drive_ramp_pkg::run_state_t run_state;
	int err_count, checks_done, th1, th2, i;
	int cfg [19];
	int lv [14] = '{1001, 1000, 950, 900, 899, 3001, 2400, 2399, 2100, 2101, 1900, 1899, 1250, 751};
	int rv [10] = '{999, 1000, 1001, 799, 800, 2050, 1950, 2000, 2250, 2399};
	logic [15:0] rst_tab [19] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h1388, 16'h0032, 16'h1388, 16'h0032, 16'h1388, 16'h0000, 16'h1388, 16'h0000,
		16'h0032, 16'h000a, 16'h07d0, 16'h0000, 16'h1388};

	drive_ramp_and_level_detect #(.tick_cycles(tk)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .feedback(fb), .cmd(cmd),
		.actual_freq(actual_freq), .ramp_sel(ramp_sel), .flags(flags), .run_state(run_state));
	drive_power_model stage (.pclk(pclk), .presetn(presetn), .target(tgt), .feedback(fb));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic end_test(input string s);
		$display("test %s done, mismatches so far %0d", s, err_count);
	endtask

	// Master holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input int idx, input int v);
		apb(1'b1, 12'(idx * 4), 32'(v));
		cfg[idx] = v;
		chk_bit(e, 1'b0, "write refused");
	endtask

	// Skip applies to steady running always, to ramps only when enabled
	function automatic int skip(input int f, input int hop, input int amp);
		if (hop == 0 || f <= hop - amp || f >= hop + amp) return f;
		if ((cmd.accelerating || cmd.decelerating) && (cfg[0] & 1) == 0) return f;
		if (cmd.accelerating) return hop + amp;
		if (cmd.decelerating) return hop - amp;
		return (f - (hop - amp) <= hop + amp - f) ? hop - amp : hop + amp;
	endfunction

	function automatic int thr(input int st, input int f, input int l, input int h);
		if (f > l) return 1;
		if (f < l - l * h / 1000) return 0;
		return st;
	endfunction

	task automatic step(input int rf, input int runf, input int of);
		int a, b, act;
		@(posedge pclk);
		tgt.ramp_freq <= 16'(rf);
		tgt.run_freq <= 16'(runf);
		tgt.out_freq <= 16'(of);
		repeat (3) @(posedge pclk);
		#1;
		th1 = thr(th1, runf, cfg[6], cfg[7]);
		th2 = thr(th2, runf, cfg[8], cfg[9]);
		a = cfg[18] * cfg[11] / 1000;
		b = cfg[18] * cfg[13] / 1000;
		act = cmd.motor1_selected && !cmd.terminal_ramp_select;
		chk_bit(flags.first_freq, th1[0], "first level");
		chk_bit(flags.second_freq, th2[0], "second level");
		chk_bit(flags.arrive_a, of - cfg[10] <= a && cfg[10] - of <= a, "arrive a");
		chk_bit(flags.arrive_b, of - cfg[12] <= b && cfg[12] - of <= b, "arrive b");
		chk_word(actual_freq, 32'(skip(skip(rf, cfg[1], cfg[3]), cfg[2], cfg[3])), "skip");
		chk_bit(ramp_sel.freq_switch_active, act[0], "switch active");
		if (cmd.accelerating) chk_bit(ramp_sel.accel_use_set2, act && runf < cfg[4], "acc");
		if (cmd.decelerating) chk_bit(ramp_sel.decel_use_set2, act && runf < cfg[5], "dec");
	endtask

	task automatic hold(input int c, input int n);
		@(posedge pclk);
		tgt.out_current <= 16'(c);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	initial begin
		#500us;
		err_count++;
		stop_test();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		tgt = '0;
		cmd = '0;
		void'($urandom(32'he825ee27));
		for (i = 0; i < 19; i++) cfg[i] = rst_tab[i];
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 19; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0);
			chk_word(rd, {16'h0000, rst_tab[i]}, "reset value");
		end
		apb(1'b0, 12'h060, 32'h0);
		chk_bit(e, 1'b1, "unmapped read");
		apb(1'b0, 12'h006, 32'h0);
		chk_bit(e, 1'b1, "misaligned read");
		apb(1'b1, 12'h04c, 32'h1);
		chk_bit(e, 1'b1, "status write");
		end_test("registers");
		// Second detector gets its own level and a wider hysteresis
		wr(6, 1000);
		wr(7, 100);
		wr(8, 3000);
		wr(9, 200);
		wr(10, 2000);
		wr(11, 20);
		wr(12, 1000);
		wr(13, 50);
		foreach (lv[k]) step(0, lv[k], lv[k]);
		for (i = 0; i < 40; i++) step(0, $urandom_range(3500), $urandom_range(3500));
		end_test("levels");
		wr(4, 1000);
		wr(5, 800);
		wr(1, 2000);
		wr(2, 2300);
		wr(3, 100);
		for (i = 0; i < 6; i++) begin
			@(posedge pclk);
			cmd.accelerating <= (i % 3 == 1);
			cmd.decelerating <= (i % 3 == 2);
			cmd.motor1_selected <= (i != 4);
			cmd.terminal_ramp_select <= (i == 5);
			wr(0, i < 3 ? 0 : 1);
			foreach (rv[k]) step(rv[k], rv[k], 0);
		end
		wr(1, 0);
		wr(2, 0);
		step(2050, 2050, 0);
		end_test("ramp");
		@(posedge pclk);
		cmd <= '0;
		wr(0, 0);
		cmd.run_cmd <= 1'b1;
		hold(0, 3);
		chk_word({29'h0, run_state}, {29'h0, drive_ramp_pkg::st_normal}, "normal");
		@(posedge pclk);
		cmd.jog_cmd <= 1'b1;
		hold(0, 3);
		chk_word({29'h0, run_state}, {29'h0, drive_ramp_pkg::st_normal}, "no priority");
		@(posedge pclk);
		cmd.jog_cmd <= 1'b0;
		wr(0, 2);
		cmd.jog_cmd <= 1'b1;
		hold(0, 3);
		chk_word({29'h0, run_state}, {29'h0, drive_ramp_pkg::st_jog}, "jog priority");
		@(posedge pclk);
		cmd <= '0;
		end_test("jog");
		// Delay of three ticks: the flag may not rise before 16 cycles
		wr(15, 3);
		hold(51, 3);
		chk_bit(flags.zero_current, 1'b0, "zero above");
		hold(50, 12);
		chk_bit(flags.zero_current, 1'b0, "zero early");
		hold(50, 10);
		chk_bit(flags.zero_current, 1'b1, "zero set");
		hold(60, 3);
		chk_bit(flags.zero_current, 1'b0, "zero drop");
		hold(40, 10);
		hold(60, 1);
		hold(40, 10);
		chk_bit(flags.zero_current, 1'b0, "restart");
		hold(40, 10);
		chk_bit(flags.zero_current, 1'b1, "zero again");
		wr(16, 1000);
		hold(999, 10);
		chk_bit(flags.over_current, 1'b0, "below limit");
		hold(1000, 2);
		chk_bit(flags.over_current, 1'b0, "oc early");
		hold(1000, 8);
		chk_bit(flags.over_current, 1'b1, "oc set");
		wr(16, 0);
		hold(3000, 12);
		chk_bit(flags.over_current, 1'b0, "oc disabled");
		end_test("current");
		stop_test();
	end
endmodule
